// >>> common/tmu_pkg.sv
// Package of constants shared by the timer unit modules.
package tmu_pkg;

	// ==========================================================
	// Geometry
	localparam int TMU_NUM_TIMERS = 3;
	localparam int TMU_CNT_W = 16;
	localparam int TMU_NUM_PINS = 4;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] TMU_TMR_STRIDE = 8'h10;
	localparam logic [7:0] TMU_OFS_CNT = 8'h00;
	localparam logic [7:0] TMU_OFS_MAXA = 8'h04;
	localparam logic [7:0] TMU_OFS_MAXB = 8'h08;
	localparam logic [7:0] TMU_OFS_CTL = 8'h0c;
	localparam logic [7:0] TMU_OFS_SYSCFG = 8'h30;
	localparam logic [7:0] TMU_OFS_IRQ = 8'h34;

	// ==========================================================
	// Timer control register fields
	localparam int TMU_CTL_CONT = 0;
	localparam int TMU_CTL_ALT = 1;
	localparam int TMU_CTL_EXT = 2;
	localparam int TMU_CTL_PRE = 3;
	localparam int TMU_CTL_RIU = 4;
	localparam int TMU_CTL_MC = 5;
	localparam int TMU_CTL_INT = 13;
	localparam int TMU_CTL_EN = 15;

	// ==========================================================
	// System configuration and request register fields
	localparam int TMU_SYSCFG_DEMOD = 6;
	localparam int TMU_IRQ_TWO = 4;
	localparam int TMU_IRQ_FOUR = 5;
	localparam int TMU_IRQ_TOP_LSB = 8;
	localparam logic [1:0] TMU_TOP_NONE = 2'h3;

	// ==========================================================
	// Pin indices in the input synchroniser
	localparam int TMU_PIN_T0 = 0;
	localparam int TMU_PIN_T1 = 1;
	localparam int TMU_PIN_TWO = 2;
	localparam int TMU_PIN_FOUR = 3;

	// ==========================================================
	// Reset values and timing
	localparam logic [15:0] TMU_REG_RST = 16'h0000;
	localparam logic [1:0] TMU_TICK_LAST = 2'h3;
	localparam logic [2:0] TMU_HSIZE_WORD = 3'h2;

endpackage : tmu_pkg

// >>> hw/tmu_timer_core.sv
// One 16-bit timer count with its limit selection and output waveform.
`timescale 1ns/1ps
`default_nettype none
module tmu_timer_core
	import tmu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic tick,
	input wire logic alt,
	input wire logic wr_cnt,
	input wire logic [15:0] wdata,
	input wire logic [15:0] max_a,
	input wire logic [15:0] max_b,
	// State
	output logic [15:0] count,
	output logic riu,
	output logic term,
	output logic pin_out
);

	logic [15:0] count_r;
	logic riu_r;
	logic pin_r;
	logic [15:0] inc;
	logic [15:0] limit;

	assign inc = count_r + 16'h0001;
	assign limit = riu_r ? max_b : max_a;
	assign term = tick && (inc == limit);
	assign count = count_r;
	assign riu = riu_r;
	assign pin_out = pin_r;

	// ==========================================================
	// Count
	// A limit of zero lets the count wrap, giving the full 65536 range.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			count_r <= TMU_REG_RST;
		else if (wr_cnt)
			count_r <= wdata;
		else if (term)
			count_r <= 16'h0000;
		else if (tick)
			count_r <= inc;
	end

	// ==========================================================
	// Limit selection and output pin
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			riu_r <= 1'b0;
		else if (!alt)
			riu_r <= 1'b0;
		else if (term)
			riu_r <= ~riu_r;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pin_r <= 1'b1;
		else if (alt)
			pin_r <= term ? riu_r : ~riu_r;
		else
			pin_r <= ~term;
	end

endmodule : tmu_timer_core
`default_nettype wire

// >>> hw/tmu_top.sv
// Timer unit with three timers, pulse-width demodulation and AHB-Lite registers.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Three independent timers, 16-bit counts each.
// - Timers 0,1 have input and output pins.
// - Timer 2 internal: delays, prescaler, DMA request.
// - Eleven 16-bit timer registers for software.
// - Counts readable and writable at any time.
// - Each timer event increments count by one.
// - Count reaching limit clears to zero immediately.
// - Timers 0,1 alternate primary/secondary limits optionally.
// - Primary-only: output low one clock at limit.
// - Dual-limit: output shows which limit controls.
// - Inputs sampled every fourth clock.
// - External clocking: output responds within six clocks; this design takes up to seven.
// - One shared timer request, priority 0,1,2.
// - Demodulation enabled by configuration bit six.
// - Demod: shared pin edges raise requests, gate timers.
// - Demod frees timer inputs and irq-four pin.
// - Limit sets flag; optional interrupt on limit.
module tmu_top
	import tmu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Timer pins
	input wire logic timer_zero_input_pin,
	input wire logic timer_one_input_pin,
	output logic timer_zero_output_pin,
	output logic timer_one_output_pin,
	// External request pins, the first doubles as demodulation pin
	input wire logic ext_irq_two,
	input wire logic ext_irq_four,
	// Requests to the system
	output logic timer_irq,
	output logic timer_dma_req,
	output logic ext_irq_two_req,
	output logic ext_irq_four_req,
	output logic pio_release
);

	// ==========================================================
	// Declarations
	logic [TMU_NUM_PINS-1:0] pin_in;
	logic [TMU_NUM_PINS-1:0] sync1_r;
	logic [TMU_NUM_PINS-1:0] sync2_r;
	logic [TMU_NUM_PINS-1:0] samp_r;
	logic [1:0] div_r;
	logic strobe;
	logic pwd_last_r;
	logic four_last_r;
	logic demod;
	logic [15:0] syscfg_r;
	logic [TMU_NUM_TIMERS-1:0] en_r;
	logic [TMU_NUM_TIMERS-1:0] cont_r;
	logic [TMU_NUM_TIMERS-1:0] alt_r;
	logic [TMU_NUM_TIMERS-1:0] ext_r;
	logic [TMU_NUM_TIMERS-1:0] pre_r;
	logic [TMU_NUM_TIMERS-1:0] inten_r;
	logic [TMU_NUM_TIMERS-1:0] mc_r;
	logic [TMU_NUM_TIMERS-1:0] tpend_r;
	logic [TMU_NUM_TIMERS-1:0] ev;
	logic [TMU_NUM_TIMERS-1:0] term;
	logic [TMU_NUM_TIMERS-1:0] riu;
	logic [TMU_NUM_TIMERS-1:0] tpin;
	logic [TMU_NUM_TIMERS-1:0] wr_cnt;
	logic [TMU_NUM_TIMERS-1:0] wr_maxa;
	logic [TMU_NUM_TIMERS-1:0] wr_maxb;
	logic [TMU_NUM_TIMERS-1:0] wr_ctl;
	logic [15:0] cnt_w [TMU_NUM_TIMERS];
	logic [15:0] maxa_r [TMU_NUM_TIMERS];
	logic [15:0] maxb_r [TMU_NUM_TIMERS];
	logic two_pend_r;
	logic four_pend_r;
	logic two_set;
	logic four_set;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [15:0] wdata;
	logic wr_syscfg;
	logic wr_irq;
	logic acc;
	logic [15:0] rd_val;
	logic [1:0] top_src;
	logic [31:0] hrdata_r;
	logic t0_out_r;
	logic t1_out_r;
	logic irq_r;
	logic dma_r;
	logic two_req_r;
	logic four_req_r;
	logic rel_r;

	assign pin_in = {ext_irq_four, ext_irq_two, timer_one_input_pin, timer_zero_input_pin};
	assign demod = syscfg_r[TMU_SYSCFG_DEMOD];

	// ==========================================================
	// Pin synchronisers and quarter-rate sampling
	genvar g;
	generate
		for (g = 0; g < TMU_NUM_PINS; g++)
		begin : g_sync
			always_ff @(posedge clk or negedge resetn)
			begin
				// Pins idle high on their pull-ups, so no false edge follows reset.
				if (!resetn)
				begin
					sync1_r[g] <= 1'b1;
					sync2_r[g] <= 1'b1;
				end
				else
				begin
					sync1_r[g] <= pin_in[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	end

	// Sampling on the quarter strobe caps the count rate and the resolution.
	assign strobe = (div_r == TMU_TICK_LAST);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			samp_r <= {TMU_NUM_PINS{1'b1}};
		else if (strobe)
			samp_r <= sync2_r;
	end

	// ==========================================================
	// Timer events
	// External edges: two sync stages plus at most three waits for the strobe,
	// then the core pin flop and the output flop, keeps the pin answer inside seven clocks.
	always_comb
	begin
		ev[2] = en_r[2] && strobe;
		for (int t = 0; t < 2; t++)
		begin
			if (demod)
				ev[t] = en_r[t] && strobe && (sync2_r[TMU_PIN_TWO] == (t == 1));
			else if (ext_r[t])
				ev[t] = en_r[t] && strobe && sync2_r[t] && !samp_r[t];
			else if (pre_r[t])
				ev[t] = en_r[t] && term[2];
			else
				ev[t] = en_r[t] && strobe;
		end
	end

	generate
		for (g = 0; g < TMU_NUM_TIMERS; g++)
		begin : g_tmr
			tmu_timer_core u_core (
				.clk(clk),
				.resetn(resetn),
				.tick(ev[g]),
				.alt(alt_r[g] && (g < 2)),
				.wr_cnt(wr_cnt[g]),
				.wdata(wdata),
				.max_a(maxa_r[g]),
				.max_b((g < 2) ? maxb_r[g] : maxa_r[g]),
				.count(cnt_w[g]),
				.riu(riu[g]),
				.term(term[g]),
				.pin_out(tpin[g])
			);

			// Non-continuous timers stop at the end of their cycle, except timer 2 with its ALT bit set, which never stops.
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					en_r[g] <= 1'b0;
					cont_r[g] <= 1'b0;
					alt_r[g] <= 1'b0;
					ext_r[g] <= 1'b0;
					pre_r[g] <= 1'b0;
					inten_r[g] <= 1'b0;
				end
				else if (wr_ctl[g])
				begin
					en_r[g] <= wdata[TMU_CTL_EN];
					cont_r[g] <= wdata[TMU_CTL_CONT];
					alt_r[g] <= wdata[TMU_CTL_ALT];
					ext_r[g] <= wdata[TMU_CTL_EXT];
					pre_r[g] <= wdata[TMU_CTL_PRE];
					inten_r[g] <= wdata[TMU_CTL_INT];
				end
				else if (term[g] && !cont_r[g] && (!alt_r[g] || riu[g]))
					en_r[g] <= 1'b0;
			end

			// Limit flag: set wins over a software clear in the same cycle.
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					mc_r[g] <= 1'b0;
				else if (term[g])
					mc_r[g] <= 1'b1;
				else if (wr_ctl[g] && !wdata[TMU_CTL_MC])
					mc_r[g] <= 1'b0;
			end

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					tpend_r[g] <= 1'b0;
				else if (term[g] && inten_r[g])
					tpend_r[g] <= 1'b1;
				else if (wr_irq && wdata[g])
					tpend_r[g] <= 1'b0;
			end

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					maxa_r[g] <= TMU_REG_RST;
					maxb_r[g] <= TMU_REG_RST;
				end
				else
				begin
					if (wr_maxa[g])
						maxa_r[g] <= wdata;
					if (wr_maxb[g] && (g < 2))
						maxb_r[g] <= wdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// External requests and demodulation edges
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pwd_last_r <= 1'b1;
			four_last_r <= 1'b1;
		end
		else
		begin
			pwd_last_r <= sync2_r[TMU_PIN_TWO];
			four_last_r <= sync2_r[TMU_PIN_FOUR];
		end
	end

	// In demod the falling edge ends a high phase (timer 1) and the rising
	// edge ends a low phase (timer 0); the request pin four is ignored.
	always_comb
	begin
		if (demod)
		begin
			two_set = pwd_last_r && !sync2_r[TMU_PIN_TWO];
			four_set = !pwd_last_r && sync2_r[TMU_PIN_TWO];
		end
		else
		begin
			two_set = !pwd_last_r && sync2_r[TMU_PIN_TWO];
			four_set = !four_last_r && sync2_r[TMU_PIN_FOUR];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			two_pend_r <= 1'b0;
		else if (two_set)
			two_pend_r <= 1'b1;
		else if (wr_irq && wdata[TMU_IRQ_TWO])
			two_pend_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			four_pend_r <= 1'b0;
		else if (four_set)
			four_pend_r <= 1'b1;
		else if (wr_irq && wdata[TMU_IRQ_FOUR])
			four_pend_r <= 1'b0;
	end

	always_comb
	begin
		if (tpend_r[0])
			top_src = 2'h0;
		else if (tpend_r[1])
			top_src = 2'h1;
		else if (tpend_r[2])
			top_src = 2'h2;
		else
			top_src = TMU_TOP_NONE;
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	// Read data is fetched in the address phase so hrdata leaves a flop.
	assign acc = hsel && hready && htrans[1] && (hsize == TMU_HSIZE_WORD);
	assign wdata = hwdata[15:0];

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= acc && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_comb
	begin
		wr_syscfg = wr_pend_r && (wr_addr_r == TMU_OFS_SYSCFG);
		wr_irq = wr_pend_r && (wr_addr_r == TMU_OFS_IRQ);
		for (int t = 0; t < TMU_NUM_TIMERS; t++)
		begin
			wr_cnt[t] = wr_pend_r && (wr_addr_r == 8'(8'(t) * TMU_TMR_STRIDE));
			wr_maxa[t] = wr_pend_r && (wr_addr_r == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_MAXA);
			wr_maxb[t] = wr_pend_r && (wr_addr_r == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_MAXB);
			wr_ctl[t] = wr_pend_r && (wr_addr_r == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_CTL);
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			syscfg_r <= TMU_REG_RST;
		else if (wr_syscfg)
			syscfg_r <= wdata;
	end

	// Unmapped words read zero and ignore writes.
	always_comb
	begin
		rd_val = 16'h0000;
		if (haddr[7:0] == TMU_OFS_SYSCFG)
			rd_val = syscfg_r;
		else if (haddr[7:0] == TMU_OFS_IRQ)
			rd_val = {6'h00, top_src, 2'h0, four_pend_r, two_pend_r, 1'b0, tpend_r};
		else
		begin
			for (int t = 0; t < TMU_NUM_TIMERS; t++)
			begin
				if (haddr[7:0] == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_CNT)
					rd_val = cnt_w[t];
				else if (haddr[7:0] == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_MAXA)
					rd_val = maxa_r[t];
				else if ((t < 2) && (haddr[7:0] == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_MAXB))
					rd_val = maxb_r[t];
				else if (haddr[7:0] == 8'(8'(t) * TMU_TMR_STRIDE) + TMU_OFS_CTL)
				begin
					rd_val[TMU_CTL_EN] = en_r[t];
					rd_val[TMU_CTL_INT] = inten_r[t];
					rd_val[TMU_CTL_MC] = mc_r[t];
					rd_val[TMU_CTL_RIU] = riu[t];
					rd_val[TMU_CTL_PRE] = pre_r[t];
					rd_val[TMU_CTL_EXT] = ext_r[t];
					rd_val[TMU_CTL_ALT] = alt_r[t];
					rd_val[TMU_CTL_CONT] = cont_r[t];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			hrdata_r <= 32'h00000000;
		else if (acc && !hwrite)
			hrdata_r <= {16'h0000, rd_val};
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			t0_out_r <= 1'b1;
			t1_out_r <= 1'b1;
			irq_r <= 1'b0;
			dma_r <= 1'b0;
			two_req_r <= 1'b0;
			four_req_r <= 1'b0;
			rel_r <= 1'b0;
		end
		else
		begin
			t0_out_r <= tpin[0];
			t1_out_r <= tpin[1];
			irq_r <= |tpend_r;
			dma_r <= term[2];
			two_req_r <= two_pend_r;
			four_req_r <= four_pend_r;
			rel_r <= demod;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign timer_zero_output_pin = t0_out_r;
	assign timer_one_output_pin = t1_out_r;
	assign timer_irq = irq_r;
	assign timer_dma_req = dma_r;
	assign ext_irq_two_req = two_req_r;
	assign ext_irq_four_req = four_req_r;
	assign pio_release = rel_r;

endmodule : tmu_top
`default_nettype wire

// >>> test/tmu_pin_model.sv
// Far side model of the timer input pins and the request pins.
`timescale 1ns/1ps
`default_nettype none
module tmu_pin_model
(
	// Clock
	input wire logic clk,
	// Commands from the bench
	input wire logic demod_go,
	input wire logic ext_go,
	// Pins
	output logic in0,
	output logic in1,
	output logic irq_two,
	output logic irq_four
);
	// ==========
	// Pin waveforms
	// Unused pins rest at their pull-up level.
	int dpos = 999;
	int epos = 999;
	assign in0 = 1'b1;
	assign irq_four = 1'b1;
	always @(posedge clk)
	begin
		dpos <= demod_go ? 0 : (dpos < 999 ? dpos + 1 : dpos);
		epos <= ext_go ? 0 : (epos < 999 ? epos + 1 : epos);
		irq_two <= !(dpos < 80 || (dpos >= 120 && dpos < 200));
		in1 <= !(epos < 80 && epos % 16 < 8);
	end
endmodule : tmu_pin_model
`default_nettype wire

// >>> test/tmu_top_chk.sv
// Port checker of the timer unit.
`timescale 1ns/1ps
`default_nettype none
module tmu_top_chk
	import tmu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and requests
	input wire logic ext_irq_two,
	input wire logic ext_irq_four,
	input wire logic timer_zero_output_pin,
	input wire logic timer_one_output_pin,
	input wire logic timer_irq,
	input wire logic timer_dma_req,
	input wire logic ext_irq_two_req,
	input wire logic ext_irq_four_req,
	input wire logic pio_release
);
	// ==========
	// Helper state
	// Edge ages start at their ceiling, so a request right after reset is an error.
	wire acc = hsel && hready && htrans[1] && hwrite && hsize == TMU_HSIZE_WORD;
	logic sys_a_r, irq_a_r, demod_r, two_r, four_r;
	logic [3:0] age2_r, age24_r;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sys_a_r <= 1'b0;
			irq_a_r <= 1'b0;
			demod_r <= 1'b0;
			two_r <= 1'b1;
			four_r <= 1'b1;
			age2_r <= 4'hf;
			age24_r <= 4'hf;
		end
		else
		begin
			sys_a_r <= acc && haddr[7:0] == TMU_OFS_SYSCFG;
			irq_a_r <= acc && haddr[7:0] == TMU_OFS_IRQ;
			if (sys_a_r)
				demod_r <= hwdata[TMU_SYSCFG_DEMOD];
			two_r <= ext_irq_two;
			four_r <= ext_irq_four;
			age2_r <= (ext_irq_two != two_r) ? 4'h0 : age2_r + 4'(age2_r != 4'hf);
			age24_r <= (ext_irq_two != two_r || ext_irq_four != four_r) ? 4'h0 :
				age24_r + 4'(age24_r != 4'hf);
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_RD_UPPER: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_DMA_PULSE: assert property (timer_dma_req |=> !timer_dma_req [*3])
		else $error("dma request faster than the event rate");
	AST_OUT0_SPACE: assert property ($rose(timer_zero_output_pin) |=>
		$stable(timer_zero_output_pin) [*2])
		else $error("timer zero output changes too soon");
	AST_OUT1_SPACE: assert property ($rose(timer_one_output_pin) |=>
		$stable(timer_one_output_pin) [*2])
		else $error("timer one output changes too soon");
	AST_PIO_FREE: assert property (pio_release == $past(demod_r))
		else $error("pin release does not follow the demodulation bit");
	AST_REQ2_EDGE: assert property ($rose(ext_irq_two_req) |-> age2_r <= 4'h8)
		else $error("request two without a recent pin edge");
	AST_REQ4_EDGE: assert property ($rose(ext_irq_four_req) |-> age24_r <= 4'h8)
		else $error("request four without a recent pin edge");
	AST_IRQ_CLR: assert property ($fell(timer_irq) |->
		$past(irq_a_r) || $past(irq_a_r, 2))
		else $error("timer request dropped without a clear");
	AST_RST_OUT: assert property ($rose(resetn) |-> timer_zero_output_pin &&
		timer_one_output_pin && !timer_irq && !timer_dma_req)
		else $error("outputs wrong after reset");
endmodule : tmu_top_chk
bind tmu_top tmu_top_chk chk_u (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking testbench of the timer unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
	import tmu_pkg::*;
;
	// ==========
	// Signals
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic dgo = 1'b0;
	logic ego = 1'b0;
	wire logic [31:0] hrdata;
	wire logic hready, hreadyout, hresp, out0, out1, irq, dma, req2, req4, prel, in0, in1, p2, p4;
	int error_cnt = 0;
	int comparisons = 0;
	int c0, c1, cd, la;
	logic [31:0] q;
	always #4 clk = ~clk;
	assign hready = hreadyout;
	tmu_top dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer_zero_input_pin(in0),
		.timer_one_input_pin(in1), .timer_zero_output_pin(out0), .timer_one_output_pin(out1),
		.ext_irq_two(p2), .ext_irq_four(p4), .timer_irq(irq), .timer_dma_req(dma),
		.ext_irq_two_req(req2), .ext_irq_four_req(req4), .pio_release(prel));
	tmu_pin_model pins_u (.clk(clk), .demod_go(dgo), .ext_go(ego), .in0(in0), .in1(in1),
		.irq_two(p2), .irq_four(p4));
	// ==========
	// Tasks
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic hwait();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 99);
		if (n >= 99)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : hwait
	task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		hwait();
		q = hrdata;
	endtask : ahb
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		ahb(1'b0, a, 16'h0);
		`CHK(q[15:0], e)
	endtask : rc
	// Counts low cycles of both outputs and dma pulses over a window.
	task automatic watch(input int len);
		c0 = 0;
		c1 = 0;
		cd = 0;
		la = 0;
		for (int i = 1; i <= len; i++)
		begin
			@(negedge clk);
			c0 += int'(out0 === 1'b0);
			c1 += int'(out1 === 1'b0);
			cd += int'(dma === 1'b1);
			if (out1 === 1'b0 && la == 0)
				la = i;
		end
		@(posedge clk);
	endtask : watch
	// ==========
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		`CHK({out0, out1, irq, dma, prel}, 5'b11000)
		@(posedge clk);
		rc(TMU_OFS_CTL, 16'h0000);
		rc(TMU_OFS_SYSCFG, 16'h0000);
		ahb(1'b1, 8'h28, 16'hbeef);
		rc(8'h28, 16'h0000);
		ahb(1'b1, TMU_OFS_CNT, 16'h1234);
		rc(TMU_OFS_CNT, 16'h1234);
		$display("test registers done");
		ahb(1'b1, 8'h24, 16'h0005);
		ahb(1'b1, 8'h2c, 16'ha001);
		for (int i = 0; i < 3; i++)
		begin
			ahb(1'b0, 8'h20, 16'h0);
			`CHK(q[15:0] < 16'h0005, 1'b1)
		end
		watch(200);
		`CHK(cd, 10)
		rc(8'h2c, 16'ha021);
		$display("test timer two done");
		ahb(1'b1, TMU_OFS_IRQ, 16'h0037);
		ahb(1'b1, TMU_OFS_CNT, 16'h0000);
		ahb(1'b1, TMU_OFS_MAXA, 16'h0002);
		ahb(1'b1, TMU_OFS_CTL, 16'ha001);
		watch(40);
		ahb(1'b1, TMU_OFS_CTL, 16'h2020);
		ahb(1'b1, 8'h2c, 16'h2020);
		rc(TMU_OFS_IRQ, 16'h0005);
		`CHK(irq, 1'b1)
		rc(TMU_OFS_CTL, 16'h2020);
		ahb(1'b1, TMU_OFS_IRQ, 16'h0001);
		rc(TMU_OFS_IRQ, 16'h0204);
		ahb(1'b1, TMU_OFS_IRQ, 16'h0004);
		rc(TMU_OFS_IRQ, 16'h0300);
		`CHK(irq, 1'b0)
		$display("test priority done");
		ahb(1'b1, 8'h14, 16'h0003);
		ahb(1'b1, 8'h1c, 16'h8001);
		watch(24);
		watch(120);
		`CHK(c1, 10)
		ahb(1'b1, 8'h1c, 16'h0000);
		ahb(1'b1, TMU_OFS_MAXB, 16'h0003);
		ahb(1'b1, TMU_OFS_CTL, 16'h8003);
		watch(40);
		watch(200);
		`CHK(c0, 120)
		ahb(1'b1, TMU_OFS_CTL, 16'h0000);
		$display("test waveforms done");
		ahb(1'b1, 8'h14, 16'h0004);
		ahb(1'b1, 8'h10, 16'h0000);
		ahb(1'b1, 8'h1c, 16'h8005);
		ego <= 1'b1;
		@(posedge clk);
		ego <= 1'b0;
		watch(100);
		`CHK(c1, 1)
		`CHK(la >= 58 && la <= 68, 1'b1)
		rc(8'h10, 16'h0001);
		$display("test external clock done");
		ahb(1'b1, TMU_OFS_MAXA, 16'h0000);
		ahb(1'b1, 8'h14, 16'h0000);
		ahb(1'b1, TMU_OFS_IRQ, 16'h0030);
		ahb(1'b1, TMU_OFS_SYSCFG, 16'h0040);
		ahb(1'b1, TMU_OFS_CNT, 16'h0000);
		ahb(1'b1, TMU_OFS_CTL, 16'h8001);
		ahb(1'b1, 8'h1c, 16'h8001);
		`CHK(prel, 1'b1)
		dgo <= 1'b1;
		@(posedge clk);
		dgo <= 1'b0;
		watch(10);
		ahb(1'b1, 8'h10, 16'h0000);
		watch(86);
		rc(TMU_OFS_CNT, 16'h0014);
		ahb(1'b1, TMU_OFS_CNT, 16'h0000);
		watch(56);
		rc(8'h10, 16'h000a);
		watch(60);
		ahb(1'b0, TMU_OFS_IRQ, 16'h0);
		`CHK(q[5:4], 2'b11)
		`CHK(req4, 1'b1)
		`CHK(req2, 1'b1)
		$display("test demodulation done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
